// ==== core/eal_core.sv ====
// Exception detection, acceptance and steering with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module eal_core (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // AXI4-Lite write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [31:0]            araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Execution core reports
  input  wire logic                   single_chip,
  input  wire logic                   acc_valid,
  input  wire logic [15:0]            acc_addr,
  input  wire logic                   instr_done,
  input  wire eal_pkg::eal_cls_e      instr_cls,
  input  wire logic                   ovf_flag,
  input  wire logic                   divisor_zero,
  input  wire logic [3:0]             trap_vector,
  input  wire logic                   seq_done,
  input  wire logic                   sw_load,
  input  wire logic                   sw_load_trace,
  input  wire logic [2:0]             sw_load_mask,
  // Interrupt requests
  input  wire logic                   nmi_req,
  input  wire logic [5:0]             ext_req,
  input  wire logic [22:0]            int_req,
  // Block transfer engine
  input  wire logic                   dtc_busy,
  output logic                        dtc_start,
  output logic [4:0]                  dtc_src,
  output logic                        cpu_halt,
  // Exception outputs and status word
  output logic                        exc_take,
  output eal_pkg::eal_kind_e          exc_kind,
  output logic [4:0]                  exc_vector,
  output logic [2:0]                  exc_level,
  output logic                        exc_saved_trace,
  output logic [2:0]                  exc_saved_mask,
  output logic                        status_trace,
  output logic [2:0]                  interrupt_mask_level
);
  import eal_pkg::*;

  // ==========================================================================
  // Register storage
  logic [7:0]  pri_q [NREG];      // priority_registers
  logic [7:0]  ten_q [NREG];      // transfer_enable_registers
  logic        ram_enable_bit_q;  // Field of ram_control_register
  // Bus state
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [15:0] aw_idx_q;          // Captured write index
  logic [7:0]  w_byte_q;          // Captured low data byte
  logic        w_strb_q;          // Low byte lane enabled
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Exception state
  logic        trace_q;           // Trace flag of status_word
  logic [2:0]  mask_q;            // interrupt_mask_level
  logic        addr_err_q;        // Pending address error
  logic        nmi_pend_q;        // Pending nonmaskable request
  logic        defer_q;           // One-instruction deferral
  logic        busy_q;            // Last value of dtc_busy
  logic        take_q, dtc_start_q, saved_tr_q;
  eal_kind_e   kind_q;
  logic [4:0]  vec_q, dtc_src_q;
  logic [2:0]  lvl_q, saved_mask_q;

  // ==========================================================================
  // Bus decode
  wire [15:0] rd_idx   = araddr[17:2];
  wire        wr_go    = aw_hold_q & w_hold_q & ~bvalid_q;
  wire        wr_pri   = (aw_idx_q >= IDX_PRI_A) && (aw_idx_q <= IDX_PRI_F);
  wire        wr_ten   = (aw_idx_q >= IDX_TEN_A) && (aw_idx_q <= IDX_TEN_F);
  wire        wr_ram   = (aw_idx_q == IDX_RAMCTL);
  wire        wr_ok    = wr_pri | wr_ten | wr_ram;
  wire [15:0] wr_poff  = aw_idx_q - IDX_PRI_A;
  wire [15:0] wr_toff  = aw_idx_q - IDX_TEN_A;
  wire        rd_pri   = (rd_idx >= IDX_PRI_A) && (rd_idx <= IDX_PRI_F);
  wire        rd_ten   = (rd_idx >= IDX_TEN_A) && (rd_idx <= IDX_TEN_F);
  wire [15:0] rd_poff  = rd_idx - IDX_PRI_A;
  wire [15:0] rd_toff  = rd_idx - IDX_TEN_A;
  wire        rd_ram   = (rd_idx == IDX_RAMCTL);
  wire        rd_stat  = (rd_idx == IDX_STATUS);
  wire        rd_ok    = rd_pri | rd_ten | rd_ram | rd_stat;
  wire [7:0]  stat_val = {1'b0, nmi_pend_q, addr_err_q, defer_q, trace_q, mask_q};
  wire [7:0]  rd_byte  = rd_pri  ? pri_q[rd_poff[2:0]] :
                         rd_ten  ? ten_q[rd_toff[2:0]] :
                         rd_ram  ? {ram_enable_bit_q, 7'h00} :
                         rd_stat ? stat_val : 8'h00;

  assign awready = ~aw_hold_q & ~bvalid_q;
  assign wready  = ~w_hold_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_idx_q  <= 16'h0000;
      w_byte_q  <= 8'h00;
      w_strb_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q  <= awaddr[17:2];
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped index answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Register writes through the low byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREG; i++) begin
        pri_q[i] <= PRI_RST;
        ten_q[i] <= TEN_RST;
      end
      ram_enable_bit_q <= RAMEN_RST;
    end else if (wr_go && w_strb_q) begin
      if (wr_pri) pri_q[wr_poff[2:0]] <= w_byte_q;
      if (wr_ten) ten_q[wr_toff[2:0]] <= w_byte_q;
      if (wr_ram) ram_enable_bit_q <= w_byte_q[RAMEN_BIT];
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Address error detection in single-chip mode
  wire in_gap  = (acc_addr >= GAP_LO) && (acc_addr <= GAP_HI);
  wire in_ram  = (acc_addr >= RAM_LO) && (acc_addr <= RAM_HI);
  wire acc_err = acc_valid & single_chip &
                 (in_gap | (in_ram & ~ram_enable_bit_q));

  // ==========================================================================
  // Per-source priority level and routing
  logic [2:0] src_lvl [NSRC];
  logic [NSRC-1:0] src_ten;
  wire  [NSRC-1:0] src_req = {int_req, ext_req};
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    // Requests 2/3 and 4/5 share fields; modules take one field each
    localparam int FLD = (s < 2) ? s : (s < 4) ? 2 : (s < NEXT) ? 3 :
                         FLD_MOD0 + (s - NEXT) / INT_PER;
    localparam int LSB = (FLD % 2 == 0) ? HI_LSB : 0;
    assign src_lvl[s] = src_req[s] ? pri_q[FLD / 2][LSB +: 3] : LVL_ZERO;
    assign src_ten[s] = ten_q[s / 8][s % 8];
  end

  // Highest level wins; lower index wins a tie; level zero never wins
  logic [2:0] best_lvl;
  logic [4:0] best_src;
  always_comb begin
    best_lvl = LVL_ZERO;
    best_src = 5'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (src_lvl[i] > best_lvl) begin
        best_lvl = src_lvl[i];
        best_src = i[4:0];
      end
    end
  end

  // ==========================================================================
  // Acceptance at instruction boundaries
  wire at_bound = instr_done & ~dtc_busy;
  wire mask_now = at_bound & (instr_cls == CLS_MASK);
  wire open_now = at_bound & ~mask_now;
  wire irq_pt   = (open_now | seq_done) & ~dtc_busy;
  wire addr_now = addr_err_q | acc_err;
  wire irq_ok   = best_lvl > mask_q;
  eal_kind_e take_kind;

  // Exception selection by priority
  always_comb begin
    take_kind = EXC_NONE;
    if (at_bound && instr_cls == CLS_INVALID) begin
      take_kind = EXC_INVALID;
    end else if (at_bound && instr_cls == CLS_TRAP) begin
      take_kind = EXC_TRAP;
    end else if (at_bound && instr_cls == CLS_TRAPV && ovf_flag) begin
      take_kind = EXC_TRAP;
    end else if (at_bound && instr_cls == CLS_DIV && divisor_zero) begin
      take_kind = EXC_ZDIV;
    end else if (open_now && addr_now) begin
      take_kind = EXC_ADDR;
    end else if (open_now && trace_q) begin
      take_kind = EXC_TRACE;
    end else if (irq_pt && nmi_pend_q) begin
      take_kind = EXC_NMI;
    end else if (irq_pt && irq_ok) begin
      take_kind = src_ten[best_src] ? EXC_DTC : EXC_IRQ;
    end
  end

  // Pending flags; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_err_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      addr_err_q <= acc_err | (addr_err_q & (take_kind != EXC_ADDR));
      nmi_pend_q <= nmi_req | (nmi_pend_q & (take_kind != EXC_NMI));
    end
  end

  // Deferral flag: set at reset, by mask instructions and transfer end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      defer_q <= 1'b1;
      busy_q  <= 1'b0;
    end else begin
      busy_q <= dtc_busy;
      if (mask_now || (busy_q && !dtc_busy)) begin
        defer_q <= 1'b1;
      end else if (open_now) begin
        defer_q <= 1'b0;
      end
    end
  end

  // Status word: all kinds but EXC_DTC clear trace; EXC_NMI and EXC_IRQ set the mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trace_q <= 1'b0;
      mask_q  <= LVL_TOP;
    end else if (take_kind == EXC_NMI) begin
      trace_q <= 1'b0;
      mask_q  <= LVL_TOP;
    end else if (take_kind == EXC_IRQ) begin
      trace_q <= 1'b0;
      mask_q  <= best_lvl;
    end else if (take_kind != EXC_NONE && take_kind != EXC_DTC) begin
      trace_q <= 1'b0;
    end else if (sw_load) begin
      trace_q <= sw_load_trace;
      mask_q  <= sw_load_mask;
    end
  end

  // Exception report and transfer engine start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      take_q       <= 1'b0;
      kind_q       <= EXC_NONE;
      vec_q        <= 5'h00;
      lvl_q        <= LVL_ZERO;
      saved_tr_q   <= 1'b0;
      saved_mask_q <= LVL_TOP;
      dtc_start_q  <= 1'b0;
      dtc_src_q    <= 5'h00;
    end else begin
      take_q      <= (take_kind != EXC_NONE) && (take_kind != EXC_DTC);
      dtc_start_q <= (take_kind == EXC_DTC);
      if (take_kind != EXC_NONE) begin
        kind_q       <= take_kind;
        saved_tr_q   <= trace_q;
        saved_mask_q <= mask_q;
        lvl_q        <= (take_kind == EXC_NMI) ? LVL_TOP : best_lvl;
        vec_q        <= (take_kind == EXC_TRAP) ? {1'b0, trap_vector} : best_src;
      end
      if (take_kind == EXC_DTC) dtc_src_q <= best_src;
    end
  end

  assign cpu_halt             = dtc_busy | dtc_start_q;
  assign dtc_start            = dtc_start_q;
  assign dtc_src              = dtc_src_q;
  assign exc_take             = take_q;
  assign exc_kind             = kind_q;
  assign exc_vector           = vec_q;
  assign exc_level            = lvl_q;
  assign exc_saved_trace      = saved_tr_q;
  assign exc_saved_mask       = saved_mask_q;
  assign status_trace         = trace_q;
  assign interrupt_mask_level = mask_q;

  // ==========================================================================
  // Assertions
  a_addr_err_held: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_err |=> addr_err_q || (take_q && kind_q == EXC_ADDR))
    else $error("address error lost");
  a_mask_defers: assert property (@(posedge aclk) disable iff (!aresetn)
    mask_now && !seq_done |=> !take_q && !dtc_start_q)
    else $error("exception taken after mask instruction");
  a_trap_always: assert property (@(posedge aclk) disable iff (!aresetn)
    at_bound && instr_cls == CLS_TRAP |=> take_q && kind_q == EXC_TRAP
      && exc_vector == {1'b0, $past(trap_vector)})
    else $error("trap not taken");
  a_trapv_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    at_bound && instr_cls == CLS_TRAPV && !ovf_flag |=> kind_q != EXC_TRAP || !take_q)
    else $error("overflow trap without overflow");
  a_trace_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    take_q && !$past(sw_load) |-> !trace_q)
    else $error("trace flag kept after exception");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    take_q && kind_q == EXC_IRQ |-> mask_q == exc_level && exc_level > exc_saved_mask)
    else $error("mask not raised to accepted level");
  a_nmi_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    take_q && kind_q == EXC_NMI |-> mask_q == LVL_TOP)
    else $error("mask not seven after nonmaskable");
  a_trace_saved: assert property (@(posedge aclk) disable iff (!aresetn)
    take_q && kind_q == EXC_TRACE |-> exc_saved_trace)
    else $error("saved trace flag not set");
  a_halt_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    dtc_busy |=> !take_q && !dtc_start_q)
    else $error("exception accepted during transfer");
  c_dtc_start: cover property (@(posedge aclk) disable iff (!aresetn) dtc_start_q);
  c_irq_take: cover property (@(posedge aclk) disable iff (!aresetn)
    take_q && kind_q == EXC_IRQ);
  c_trace_take: cover property (@(posedge aclk) disable iff (!aresetn)
    take_q && kind_q == EXC_TRACE);
endmodule
`default_nettype wire

// ==== inc/eal_pkg.sv ====
// Package: constants and types of the exception acceptance logic
package eal_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_PRI_A   = 16'hFF00;  // First priority register
  localparam logic [15:0] IDX_PRI_F   = 16'hFF05;  // Last priority register
  localparam logic [15:0] IDX_TEN_A   = 16'hFF08;  // First transfer enable register
  localparam logic [15:0] IDX_TEN_F   = 16'hFF0D;  // Last transfer enable register
  localparam logic [15:0] IDX_RAMCTL  = 16'hFF10;  // RAM control register
  localparam logic [15:0] IDX_STATUS  = 16'hFF11;  // Read-only status register
  localparam int          NREG        = 6;         // Registers per bank
  localparam logic [7:0]  PRI_RST     = 8'h00;     // Priority register reset
  localparam logic [7:0]  TEN_RST     = 8'h00;     // Transfer enable reset
  localparam logic        RAMEN_RST   = 1'b1;      // RAM enabled after reset
  localparam int          RAMEN_BIT   = 7;         // ram_enable_bit position
  localparam logic [1:0]  RESP_OKAY   = 2'h0;      // AXI OKAY
  localparam logic [1:0]  RESP_SLVERR = 2'h2;      // AXI SLVERR
  // ==========================================================================
  // Address map checks in single-chip mode
  localparam logic [15:0] GAP_LO = 16'h8000;  // Unpopulated range start
  localparam logic [15:0] GAP_HI = 16'hF67F;  // Unpopulated range end
  localparam logic [15:0] RAM_LO = 16'hF680;  // Internal RAM start
  localparam logic [15:0] RAM_HI = 16'hFE7F;  // Internal RAM end
  // ==========================================================================
  // Sources and levels
  localparam int         NEXT     = 6;      // External maskable requests
  localparam int         NINT     = 23;     // Internal requests
  localparam int         NSRC     = NEXT + NINT;
  localparam int         INT_PER  = 3;      // Internal requests per module field
  localparam int         FLD_MOD0 = 4;      // First module field
  localparam logic [2:0] LVL_ZERO = 3'h0;   // Level never accepted
  localparam logic [2:0] LVL_TOP  = 3'h7;   // Mask level after reset and NMI
  localparam int         HI_LSB   = 4;      // Upper field of a priority register
  // ==========================================================================
  // Instruction classes reported at completion
  typedef enum logic [2:0] {
    CLS_PLAIN, CLS_MASK, CLS_TRAP, CLS_TRAPV, CLS_DIV, CLS_INVALID
  } eal_cls_e;
  // Accepted exception kinds
  typedef enum logic [3:0] {
    EXC_NONE, EXC_INVALID, EXC_TRAP, EXC_ZDIV, EXC_ADDR, EXC_TRACE,
    EXC_NMI, EXC_IRQ, EXC_DTC
  } eal_kind_e;
endpackage

// ==== testbench/eal_core_model.sv ====
// Execution core and transfer engine stand-in facing the exception logic
`timescale 1ns/1ps
`default_nettype none
module eal_core_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench command and engine start
  input  wire logic go,
  input  wire logic cpu_halt,
  input  wire logic dtc_start,
  // Core reports
  output logic      instr_done,
  output logic      dtc_busy
);
  logic [2:0] busy_q;  // Engine cycles left
  // ==========================================
  // No instruction completes while halted; engine works four cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_done <= 1'b0;
      busy_q     <= 3'h0;
    end else begin
      instr_done <= go & !cpu_halt;
      busy_q     <= dtc_start ? 3'h4 : busy_q - {2'h0, busy_q != 3'h0};
    end
  end
  assign dtc_busy = busy_q != 3'h0;
endmodule
`default_nettype wire

// ==== testbench/eal_core_bench.sv ====
// Self-checking bench of the exception acceptance logic
`timescale 1ns/1ps
`default_nettype none
module eal_core_bench;
  import eal_pkg::*;
  typedef struct packed {
    logic [7:0] pri; logic [5:0] ext; logic [2:0] msk; logic tk; logic [4:0] vec; logic [2:0] lvl;
  } eal_row_s;
  // Rows: priority A, requests, start mask, taken, vector, level
  eal_row_s rows[5] = '{'{8'h50, 6'h01, 3'h0, 1'b1, 5'h00, 3'h5},
                        '{8'h00, 6'h01, 3'h0, 1'b0, 5'h00, 3'h0},
                        '{8'h35, 6'h03, 3'h0, 1'b1, 5'h01, 3'h5},
                        '{8'h55, 6'h03, 3'h0, 1'b1, 5'h00, 3'h5},
                        '{8'h50, 6'h01, 3'h5, 1'b0, 5'h00, 3'h0}};
  logic aclk = 0, aresetn = 0, go = 0, rdy = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic single_chip = 0, acc_valid = 0, ovf_flag = 0, divisor_zero = 0, sw_load = 0;
  logic sw_load_trace = 0, instr_done, dtc_busy, awready, wready, bvalid, arready, rvalid;
  logic dtc_start, cpu_halt, exc_take, exc_saved_trace, status_trace;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [15:0] acc_addr = 0;
  logic [3:0] trap_vector = 0;
  logic [5:0] ext_req = 0;
  logic [4:0] dtc_src, exc_vector;
  logic [2:0] sw_load_mask = 0, exc_level, exc_saved_mask, interrupt_mask_level;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d;
  eal_cls_e instr_cls = CLS_PLAIN;
  eal_kind_e exc_kind;
  int mismatches = 0, checked = 0;
  always #4 aclk = ~aclk;
  eal_core eal_core_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready(rdy), .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready(rdy), .rdata, .rresp, .single_chip, .acc_valid, .acc_addr, .instr_done, .instr_cls,
    .ovf_flag, .divisor_zero, .trap_vector, .seq_done(1'b0), .sw_load, .sw_load_trace,
    .sw_load_mask, .nmi_req(1'b0), .ext_req, .int_req(23'h0), .dtc_busy, .dtc_start, .dtc_src,
    .cpu_halt, .exc_take, .exc_kind, .exc_vector, .exc_level, .exc_saved_trace, .exc_saved_mask,
    .status_trace, .interrupt_mask_level);
  eal_core_model eal_core_model_inst (.aclk, .aresetn, .go, .cpu_halt, .dtc_start, .instr_done,
    .dtc_busy);
  // ==========================================
  // Comparison, verdict and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] rs);
    logic ta, tw, ka, kw, kb;
    ta = 0;
    tw = 0;
    @(posedge aclk) begin
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= {14'h0, idx, 2'h0};
      wdata <= {24'h00_0000, v};
    end
    while (!(ta && tw)) begin
      #1 ka = awready;
      kw = wready;
      @(posedge aclk);
      if (ka && !ta) begin awvalid <= 0; ta = 1; end
      if (kw && !tw) begin wvalid <= 0; tw = 1; end
    end
    do begin #1 kb = bvalid; rs = bresp; @(posedge aclk); end while (!kb);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] rs);
    logic k;
    @(posedge aclk) begin arvalid <= 1; araddr <= {14'h0, idx, 2'h0}; end
    do begin #1 k = arready; @(posedge aclk); end while (!k);
    arvalid <= 0;
    do begin #1 k = rvalid; v = rdata[7:0]; rs = rresp; @(posedge aclk); end while (!k);
  endtask
  // Status word load by the core
  task automatic ld(input logic t, input logic [2:0] m);
    @(posedge aclk) begin sw_load <= 1; sw_load_trace <= t; sw_load_mask <= m; end
    @(posedge aclk) sw_load <= 0;
  endtask
  // One memory access report
  task automatic acc(input logic [15:0] a);
    @(posedge aclk) begin acc_valid <= 1; acc_addr <= a; end
    @(posedge aclk) acc_valid <= 0;
  endtask
  // One completed instruction, then the answer one edge later
  task automatic step(input eal_cls_e c, input logic tk, input eal_kind_e k, input logic dt);
    @(posedge aclk) begin go <= 1; instr_cls <= c; end
    @(posedge aclk) go <= 0;
    @(posedge aclk);
    #1 chk(exc_take, tk);
    chk(dtc_start, dt);
    if (tk) chk(exc_kind, k);
  endtask
  // ==========================================
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    summarize();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    #1 chk(interrupt_mask_level, LVL_TOP);
    chk(status_trace, 1'b0);
    foreach (rows[i]) begin
      ld(1'b0, rows[i].msk);
      wr(IDX_PRI_A, rows[i].pri, r);
      ext_req <= rows[i].ext;
      step(CLS_PLAIN, rows[i].tk, EXC_IRQ, 1'b0);
      if (rows[i].tk) begin
        chk(exc_vector, rows[i].vec);
        chk(interrupt_mask_level, rows[i].lvl);
        chk(exc_level, rows[i].lvl);
      end
      ext_req <= 0;
    end
    ld(1'b0, 3'h0);
    ext_req <= 1;
    step(CLS_MASK, 1'b0, EXC_NONE, 1'b0);
    step(CLS_PLAIN, 1'b1, EXC_IRQ, 1'b0);
    ext_req <= 0;
    ld(1'b0, 3'h0);
    trap_vector <= 4'hF;
    step(CLS_TRAP, 1'b1, EXC_TRAP, 1'b0);
    chk(exc_vector, 5'h0F);
    chk(interrupt_mask_level, 3'h0);
    step(CLS_TRAPV, 1'b0, EXC_NONE, 1'b0);
    ovf_flag <= 1;
    step(CLS_TRAPV, 1'b1, EXC_TRAP, 1'b0);
    divisor_zero <= 1;
    step(CLS_DIV, 1'b1, EXC_ZDIV, 1'b0);
    step(CLS_INVALID, 1'b1, EXC_INVALID, 1'b0);
    ld(1'b1, 3'h3);
    step(CLS_PLAIN, 1'b1, EXC_TRACE, 1'b0);
    chk(status_trace, 1'b0);
    chk(interrupt_mask_level, 3'h3);
    chk(exc_saved_trace, 1'b1);
    chk(exc_saved_mask, 3'h3);
    ld(1'b1, 3'h3);
    single_chip <= 1;
    acc(GAP_LO);
    step(CLS_PLAIN, 1'b1, EXC_ADDR, 1'b0);
    chk(status_trace, 1'b0);
    chk(interrupt_mask_level, 3'h3);
    wr(IDX_RAMCTL, 8'h00, r);
    acc(RAM_HI);
    step(CLS_PLAIN, 1'b1, EXC_ADDR, 1'b0);
    wr(IDX_RAMCTL, 8'h80, r);
    acc(RAM_LO);
    step(CLS_PLAIN, 1'b0, EXC_NONE, 1'b0);
    ld(1'b0, 3'h0);
    wr(IDX_TEN_A, 8'h01, r);
    chk(r, RESP_OKAY);
    wr(IDX_PRI_A, 8'h50, r);
    ext_req <= 1;
    step(CLS_PLAIN, 1'b0, EXC_NONE, 1'b1);
    chk(cpu_halt, 1'b1);
    chk(dtc_src, 5'h00);
    ext_req <= 0;
    rd(IDX_TEN_A, d, r);
    chk(d, 8'h01);
    rd(16'hFF20, d, r);
    chk(r, RESP_SLVERR);
    summarize();
  end
endmodule
`default_nettype wire
